// *** rtl/dsm_pkg.sv ***
// Package: register map, field positions, reset values and types of the DMA channel
package dsm_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] DSM_OFS_CHANNEL_CONTROL = 8'h00;
	localparam logic [7:0] DSM_OFS_MEMORY_ADDRESS = 8'h04;
	localparam logic [7:0] DSM_OFS_IO_ADDRESS_LOW = 8'h08;
	localparam logic [7:0] DSM_OFS_TRANSFER_COUNT = 8'h0C;
	localparam logic [7:0] DSM_OFS_CHANNEL_PAIR_CONTROL = 8'h10;
	localparam logic [7:0] DSM_OFS_STATUS = 8'h14;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int DSM_BIT_CHANNEL_ENABLE = 0;
	localparam int DSM_BIT_END_INTERRUPT_ENABLE = 1;
	localparam int DSM_BIT_REPEAT_ENABLE = 2;
	localparam int DSM_BIT_DIRECTION_SELECT = 3;
	localparam int DSM_BIT_TRANSFER_SIZE = 4;
	localparam int DSM_BIT_ADDRESS_STEP_DIRECTION = 5;
	localparam int DSM_POS_SOURCE_SELECT = 8;
	localparam int DSM_BIT_SINGLE_ADDR_SELECT = 0;
	localparam int DSM_BIT_STATUS_BUSY = 0;
	localparam int DSM_BIT_STATUS_PENDING = 1;

	// ------------------------------------------------------------
	// Reset values and fixed patterns
	// ------------------------------------------------------------
	localparam logic [31:0] DSM_RST_REG = 32'h0000_0000;
	localparam logic [7:0] DSM_IO_HIGH_BYTE = 8'hFF;
	localparam logic [15:0] DSM_COUNT_LAST = 16'h0001;
	localparam logic [7:0] DSM_HALF_LAST = 8'h01;

	// ------------------------------------------------------------
	// Activation source selector codes
	// ------------------------------------------------------------
	localparam logic [3:0] DSM_SRC_CONVERTER_END = 4'h0;
	localparam logic [3:0] DSM_SRC_EXT_REQUEST = 4'h1;
	localparam logic [3:0] DSM_SRC_SERIAL_TX_DONE = 4'h2;
	localparam logic [3:0] DSM_SRC_SERIAL_RX_FULL = 4'h3;
	localparam logic [3:0] DSM_SRC_TIMER_BASE = 4'h4;
	localparam int DSM_TIMER_CHANNELS = 6;

	typedef enum logic [0:0] {
		DSM_ST_WAIT = 1'b0,
		DSM_ST_ISSUE = 1'b1
	} dsm_state_t;

	// Request pulses from the on-chip sources
	typedef struct packed {
		logic converter_end;
		logic ext_request;
		logic serial_tx_done;
		logic serial_rx_full;
		logic [DSM_TIMER_CHANNELS-1:0] timer_capture;
	} dsm_act_src_t;

	// One transfer handed to the internal bus
	typedef struct packed {
		logic [23:0] src_addr;
		logic [23:0] dst_addr;
		logic word;
		logic single;
	} dsm_xfer_t;

endpackage

// *** rtl/dsm_channel.sv ***
// One short address mode DMA channel with its APB register file
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Overview of operation
// - Repeat plus end-interrupt enable selects idle mode
// - Idle mode keeps memory address fixed
// - Second address is FF over io_address_low
// - Count decrements; zero clears enable, stops channel
// - Count end with interrupt enable raises request
// - Zero count means 65,536 transfers
// - Converter, external, serial, timer 0-5 activate
// - External request only accepted on channel B
// - Repeat without end interrupt selects repeat mode
// - Repeat: one transfer per request, address updated
// - Address steps 1 or 2, up or down
// - Count-down half reloads from hold at zero
// - Reload restores address by step times hold
// - Both halves zero mean 256 per cycle
// - Repeat runs until disabled, never interrupts
// - Re-enable resumes with next transfer, state kept
// - Direction zero: memory source; one: destination
// - Single address mode only on channel B
// - Pair control select bit enables single address
// - Strobe replaces io address; write or read
// - Memory and strobe access share one cycle
// ------------------------------------------------------------
module dsm_channel
	import dsm_pkg::*;
#(
	parameter bit CHANNEL_B = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dsm_act_src_t act_src,
	output dsm_xfer_t xfer_cmd,
	output logic xfer_valid,
	input wire logic xfer_done,
	output logic transfer_ack_strobe_n,
	output logic ack_is_read,
	output logic end_irq
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic channel_enable, end_interrupt_enable, repeat_enable;
	logic direction_select, transfer_size, address_step_direction;
	logic [3:0] source_select;
	logic single_addr_select;
	logic [23:0] memory_address;
	logic [15:0] io_address_low;
	logic [15:0] transfer_count;
	logic pending;
	dsm_state_t state;

	logic next_channel_enable, next_end_interrupt_enable, next_repeat_enable;
	logic next_direction_select, next_transfer_size, next_address_step_direction;
	logic [3:0] next_source_select;
	logic next_single_addr_select;
	logic [23:0] next_memory_address;
	logic [15:0] next_io_address_low;
	logic [15:0] next_transfer_count;
	logic next_pending;
	dsm_state_t next_state;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	dsm_xfer_t next_xfer_cmd;
	logic next_xfer_valid, next_strobe_n, next_ack_is_read, next_end_irq;

	// ------------------------------------------------------------
	// Derived controls
	// ------------------------------------------------------------
	logic idle_mode, rep_mode, single_mode, trigger, wr_take, rd_phase;
	logic [9:0] src_vec;
	logic [23:0] step, stepped, restore_delta;
	logic [8:0] hold_count;
	logic [7:0] down_minus;
	logic [15:0] count_minus;
	logic [23:0] io_full;

	// Mode decode from the two enable bits
	assign idle_mode = repeat_enable & end_interrupt_enable;
	assign rep_mode = repeat_enable & ~end_interrupt_enable;
	// Channel A ignores the pair select bit
	assign single_mode = CHANNEL_B & single_addr_select;
	// Upper byte of the io side is fixed
	assign io_full = {DSM_IO_HIGH_BYTE, io_address_low};
	// Byte step 1, word step 2
	assign step = transfer_size ? 24'h00_0002 : 24'h00_0001;
	assign stepped = address_step_direction ? memory_address - step : memory_address + step;
	// Zero hold counts as 256 per repeat cycle
	assign hold_count = {(transfer_count[15:8] == 8'h00), transfer_count[15:8]};
	assign restore_delta = transfer_size ? {14'h0000, hold_count, 1'b0}
		: {15'h0000, hold_count};
	// Repeat uses the low half, the other modes the whole count
	assign down_minus = transfer_count[7:0] - 8'h01;
	// Wraps from zero, giving the full 65,536 run
	assign count_minus = transfer_count - 16'h0001;
	// A write lands in the cycle pready stands
	assign wr_take = psel & penable & pready & pwrite;
	assign rd_phase = psel & penable & ~pready;

	// Source pulses in selector order
	assign src_vec = {act_src.timer_capture, act_src.serial_rx_full, act_src.serial_tx_done,
		act_src.ext_request, act_src.converter_end};

	// ------------------------------------------------------------
	// Activation source select
	// ------------------------------------------------------------
	always_comb begin
		// One-deep: requests before the issue merge into one
		trigger = 1'b0;
		if (source_select == DSM_SRC_EXT_REQUEST) begin
			// Channel A has no external request path
			trigger = CHANNEL_B & act_src.ext_request;
		end else if (source_select <= 4'h9) begin
			trigger = src_vec[source_select];
		end
	end

	// ------------------------------------------------------------
	// Next-state logic: registers, transfer engine, bus slave
	// ------------------------------------------------------------
	always_comb begin
		next_channel_enable = channel_enable;
		next_end_interrupt_enable = end_interrupt_enable;
		next_repeat_enable = repeat_enable;
		next_direction_select = direction_select;
		next_transfer_size = transfer_size;
		next_address_step_direction = address_step_direction;
		next_source_select = source_select;
		next_single_addr_select = single_addr_select;
		next_memory_address = memory_address;
		next_io_address_low = io_address_low;
		next_transfer_count = transfer_count;
		next_state = state;
		next_xfer_cmd = xfer_cmd;
		next_xfer_valid = xfer_valid;
		next_strobe_n = 1'b1;
		next_ack_is_read = ack_is_read;
		next_end_irq = 1'b0;
		next_pending = pending;

		// Engine; a disabled channel keeps address and count
		case (state)
			DSM_ST_WAIT: begin
				if (channel_enable && pending) begin
					// Memory side is the source unless direction is set
					if (direction_select) begin
						next_xfer_cmd.src_addr = io_full;
						next_xfer_cmd.dst_addr = memory_address;
					end else begin
						next_xfer_cmd.src_addr = memory_address;
						next_xfer_cmd.dst_addr = io_full;
					end
					next_xfer_cmd.word = transfer_size;
					// Bus performs memory side only; strobe covers the device
					next_xfer_cmd.single = single_mode;
					next_xfer_valid = 1'b1;
					next_strobe_n = ~single_mode;
					next_ack_is_read = direction_select;
					next_pending = 1'b0;
					next_state = DSM_ST_ISSUE;
				end
			end
			DSM_ST_ISSUE: begin
				// Strobe held for the whole shared access
				next_strobe_n = ~xfer_cmd.single;
				if (xfer_done) begin
					next_xfer_valid = 1'b0;
					next_strobe_n = 1'b1;
					next_state = DSM_ST_WAIT;
					if (rep_mode) begin
						// Step first; the rewind below undoes a whole block
						next_memory_address = stepped;
						if (transfer_count[7:0] == DSM_HALF_LAST) begin
							// Rewind the block; no end request in this mode
							next_transfer_count[7:0] = transfer_count[15:8];
							next_memory_address = address_step_direction
								? stepped + restore_delta
								: stepped - restore_delta;
						end else begin
							next_transfer_count[7:0] = down_minus;
						end
					end else begin
						if (!idle_mode) begin
							next_memory_address = stepped;
						end
						// Idle mode: address left as is
						next_transfer_count = count_minus;
						if (transfer_count == DSM_COUNT_LAST) begin
							next_channel_enable = 1'b0;
							next_end_irq = end_interrupt_enable;
						end
					end
				end
			end
			default: begin
				next_state = DSM_ST_WAIT;
			end
		endcase

		// New request wins over the clear on issue
		if (trigger) begin
			next_pending = 1'b1;
		end

		// Software writes land last, so a set of enable beats the end clear
		if (wr_take) begin
			if (paddr == DSM_OFS_CHANNEL_CONTROL) begin
				next_channel_enable = pwdata[DSM_BIT_CHANNEL_ENABLE];
				next_end_interrupt_enable = pwdata[DSM_BIT_END_INTERRUPT_ENABLE];
				next_repeat_enable = pwdata[DSM_BIT_REPEAT_ENABLE];
				next_direction_select = pwdata[DSM_BIT_DIRECTION_SELECT];
				next_transfer_size = pwdata[DSM_BIT_TRANSFER_SIZE];
				next_address_step_direction = pwdata[DSM_BIT_ADDRESS_STEP_DIRECTION];
				next_source_select = pwdata[DSM_POS_SOURCE_SELECT +: 4];
			end else if (paddr == DSM_OFS_MEMORY_ADDRESS) begin
				next_memory_address = pwdata[23:0];
			end else if (paddr == DSM_OFS_IO_ADDRESS_LOW) begin
				next_io_address_low = pwdata[15:0];
			end else if (paddr == DSM_OFS_TRANSFER_COUNT) begin
				// High byte is count_hold, low byte count_down
				next_transfer_count = pwdata[15:0];
			end else if (paddr == DSM_OFS_CHANNEL_PAIR_CONTROL) begin
				next_single_addr_select = pwdata[DSM_BIT_SINGLE_ADDR_SELECT];
			end
		end
	end

	// ------------------------------------------------------------
	// APB answer
	// ------------------------------------------------------------
	// One wait state, so every bus output comes from a flop
	always_comb begin
		next_pready = rd_phase;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		if (rd_phase) begin
			if (paddr == DSM_OFS_CHANNEL_CONTROL) begin
				next_prdata[DSM_BIT_CHANNEL_ENABLE] = channel_enable;
				next_prdata[DSM_BIT_END_INTERRUPT_ENABLE] = end_interrupt_enable;
				next_prdata[DSM_BIT_REPEAT_ENABLE] = repeat_enable;
				next_prdata[DSM_BIT_DIRECTION_SELECT] = direction_select;
				next_prdata[DSM_BIT_TRANSFER_SIZE] = transfer_size;
				next_prdata[DSM_BIT_ADDRESS_STEP_DIRECTION] = address_step_direction;
				next_prdata[DSM_POS_SOURCE_SELECT +: 4] = source_select;
			end else if (paddr == DSM_OFS_MEMORY_ADDRESS) begin
				next_prdata[23:0] = memory_address;
			end else if (paddr == DSM_OFS_IO_ADDRESS_LOW) begin
				next_prdata[15:0] = io_address_low;
			end else if (paddr == DSM_OFS_TRANSFER_COUNT) begin
				next_prdata[15:0] = transfer_count;
			end else if (paddr == DSM_OFS_CHANNEL_PAIR_CONTROL) begin
				next_prdata[DSM_BIT_SINGLE_ADDR_SELECT] = single_addr_select;
			end else if (paddr == DSM_OFS_STATUS) begin
				next_prdata[DSM_BIT_STATUS_BUSY] = (state == DSM_ST_ISSUE);
				next_prdata[DSM_BIT_STATUS_PENDING] = pending;
			end else begin
				// Unmapped: error, read data zero
				next_pslverr = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_enable <= DSM_RST_REG[0];
			end_interrupt_enable <= DSM_RST_REG[0];
			repeat_enable <= DSM_RST_REG[0];
			direction_select <= DSM_RST_REG[0];
			transfer_size <= DSM_RST_REG[0];
			address_step_direction <= DSM_RST_REG[0];
			source_select <= DSM_RST_REG[3:0];
			single_addr_select <= DSM_RST_REG[0];
			memory_address <= DSM_RST_REG[23:0];
			io_address_low <= DSM_RST_REG[15:0];
			transfer_count <= DSM_RST_REG[15:0];
		end else begin
			channel_enable <= next_channel_enable;
			end_interrupt_enable <= next_end_interrupt_enable;
			repeat_enable <= next_repeat_enable;
			direction_select <= next_direction_select;
			transfer_size <= next_transfer_size;
			address_step_direction <= next_address_step_direction;
			source_select <= next_source_select;
			single_addr_select <= next_single_addr_select;
			memory_address <= next_memory_address;
			io_address_low <= next_io_address_low;
			transfer_count <= next_transfer_count;
		end
	end

	// Engine and strobe registers; strobe idles high out of reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= 1'b0;
			state <= DSM_ST_WAIT;
			xfer_cmd <= '0;
			xfer_valid <= 1'b0;
			transfer_ack_strobe_n <= 1'b1;
			ack_is_read <= 1'b0;
			end_irq <= 1'b0;
		end else begin
			pending <= next_pending;
			state <= next_state;
			xfer_cmd <= next_xfer_cmd;
			xfer_valid <= next_xfer_valid;
			transfer_ack_strobe_n <= next_strobe_n;
			ack_is_read <= next_ack_is_read;
			end_irq <= next_end_irq;
		end
	end

	// Bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= DSM_RST_REG;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

endmodule
`default_nettype wire

// *** tb/dsm_bus_model.sv ***
// Internal bus model that finishes each transfer the channel issues
`timescale 1ns/1ps
`default_nettype none
module dsm_bus_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic xfer_valid,
	input wire logic [3:0] delay,
	output logic xfer_done
);
	logic [3:0] wait_cnt;

	// --------------------------------------------
	// Done pulse
	// --------------------------------------------
	// One pulse per transfer after the chosen wait; never answers when idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt <= 4'h0;
			xfer_done <= 1'b0;
		end else if (xfer_done || !xfer_valid) begin
			wait_cnt <= 4'h0;
			xfer_done <= 1'b0;
		end else if (wait_cnt >= delay) begin
			xfer_done <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** tb/dsm_channel_assertions.sv ***
// Checker of the channel's transfer port behaviour
`timescale 1ns/1ps
`default_nettype none
module dsm_channel_chk
	import dsm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire dsm_xfer_t xfer_cmd,
	input wire logic xfer_valid,
	input wire logic xfer_done,
	input wire logic transfer_ack_strobe_n,
	input wire logic end_irq
);
	// --------------------------------------------
	// Properties
	// --------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_io_high;
		xfer_valid && !xfer_cmd.single |-> (xfer_cmd.src_addr[23:16] == DSM_IO_HIGH_BYTE ||
			xfer_cmd.dst_addr[23:16] == DSM_IO_HIGH_BYTE);
	endproperty
	a_io_high: assert property (p_io_high) else $error("io side lacks FF high byte");
	property p_strobe_single;
		xfer_valid && xfer_cmd.single |-> !transfer_ack_strobe_n;
	endproperty
	a_strobe_single: assert property (p_strobe_single) else $error("strobe idle");
	property p_strobe_idle;
		!xfer_valid |-> transfer_ack_strobe_n;
	endproperty
	a_strobe_idle: assert property (p_strobe_idle) else $error("strobe outside transfer");
	property p_same_cycle;
		$fell(transfer_ack_strobe_n) |-> $rose(xfer_valid) && xfer_cmd.single;
	endproperty
	a_same_cycle: assert property (p_same_cycle) else $error("strobe not with memory");
	property p_hold_cmd;
		xfer_valid && !xfer_done |=> xfer_valid && $stable(xfer_cmd);
	endproperty
	a_hold_cmd: assert property (p_hold_cmd) else $error("transfer not held");
	property p_done_drop;
		xfer_valid && xfer_done |=> !xfer_valid;
	endproperty
	a_done_drop: assert property (p_done_drop) else $error("transfer not ended");
	property p_irq_cause;
		end_irq |-> $past(xfer_valid) && $past(xfer_done) && !xfer_valid;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("end request w/o transfer");
	property p_irq_pulse;
		end_irq |=> !end_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("end request too long");
endmodule
bind dsm_channel dsm_channel_chk u_chk (
	.pclk(pclk),
	.presetn(presetn),
	.xfer_cmd(xfer_cmd),
	.xfer_valid(xfer_valid),
	.xfer_done(xfer_done),
	.transfer_ack_strobe_n(transfer_ack_strobe_n),
	.end_irq(end_irq)
);
`default_nettype wire

// *** tb/dsm_channel_tb.sv ***
// Self-checking testbench of the short address mode channel
`timescale 1ns/1ps
`default_nettype none
module dsm_channel_tb;
	import dsm_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic xfer_valid, xfer_done, strobe_n, ack_is_read, end_irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] delay;
	dsm_act_src_t act_src;
	dsm_xfer_t xfer_cmd;
	int failures, checks_done, cycles;
	logic a_valid, a_strobe_n;
	dsm_xfer_t a_cmd;
	int a_issues, a_single;

	dsm_channel uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .act_src(act_src), .xfer_cmd(xfer_cmd), .xfer_valid(xfer_valid),
		.xfer_done(xfer_done), .transfer_ack_strobe_n(strobe_n), .ack_is_read(ack_is_read),
		.end_irq(end_irq));
	dsm_bus_model bus (.pclk(pclk), .presetn(presetn), .xfer_valid(xfer_valid),
		.delay(delay), .xfer_done(xfer_done));
	// Channel A twin on the same bus: must never take the external request or strobe
	dsm_channel #(.CHANNEL_B(1'b0)) uut_a (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
		.pready(), .pslverr(), .act_src(act_src), .xfer_cmd(a_cmd), .xfer_valid(a_valid),
		.xfer_done(xfer_done), .transfer_ack_strobe_n(a_strobe_n), .ack_is_read(),
		.end_irq());
	// Channel A activity, looked at between edges where it is settled
	always @(negedge pclk) begin
		if (a_valid === 1'b1) a_issues++;
		if (a_valid === 1'b1 && (a_cmd.single !== 1'b0 || a_strobe_n !== 1'b1)) a_single++;
	end

	// --------------------------------------------
	// Clock, timeout and closing
	// --------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Ceiling sized for about 300 transfers plus register traffic
	always @(posedge pclk) begin
		cycles++;
		if (cycles > 20000) begin
			failures++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// --------------------------------------------
	// Bus and transfer helpers
	// --------------------------------------------
	// Request held until pready is sampled high; data taken at that edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic err);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		check("pready", 1, pready);
		check("pslverr", err, pslverr);
		if (!wr) check("prdata", exp, prdata);
		// Edge that samples pready high; the write lands here
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [31:0] ctl(input logic [5:0] b, input logic [3:0] s);
		return {20'h0, s, 2'b00, b};
	endfunction
	function automatic logic [9:0] bitof(input int c);
		return (c < 4) ? (10'h200 >> c) : (10'h001 << (c - 4));
	endfunction
	// Pulse a request, then judge the issued command and the end request
	task automatic xfer(input logic [9:0] s, input logic [49:0] exp, input logic [49:0] m,
		input logic rd, input logic irq);
		int n;
		act_src <= s;
		@(posedge pclk);
		act_src <= '0;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (xfer_valid !== 1'b1 && n < 40);
		check("xfer_cmd", {14'h0, exp & m}, {14'h0, xfer_cmd & m});
		check("strobe_n", !exp[0], strobe_n);
		if (exp[0]) check("ack_is_read", rd, ack_is_read);
		while (xfer_valid === 1'b1 && n < 80) begin
			@(negedge pclk);
			n++;
		end
		check("end_irq", irq, end_irq);
		@(posedge pclk);
	endtask
	localparam logic [49:0] ALL = '1;

	// --------------------------------------------
	// Scenarios
	// --------------------------------------------
	task automatic test_regs();
		for (int a = 0; a < 6; a++) apb(0, 8'(4 * a), 0, 0, 0);
		apb(0, 8'h20, 0, 0, 1);
		apb(1, DSM_OFS_MEMORY_ADDRESS, 32'h0012_3456, 0, 0);
		apb(0, DSM_OFS_MEMORY_ADDRESS, 0, 32'h0012_3456, 0);
		$display("test regs done");
	endtask
	task automatic test_idle();
		apb(1, DSM_OFS_MEMORY_ADDRESS, 32'h0000_1000, 0, 0);
		apb(1, DSM_OFS_IO_ADDRESS_LOW, 32'h0000_1234, 0, 0);
		apb(1, DSM_OFS_TRANSFER_COUNT, 32'h0000_0003, 0, 0);
		apb(1, DSM_OFS_CHANNEL_CONTROL, ctl(6'h07, 4'h0), 0, 0);
		for (int i = 0; i < 3; i++) begin
			xfer(bitof(0), {24'h001000, 24'hFF1234, 2'b00}, ALL, 0, i == 2);
		end
		apb(0, DSM_OFS_CHANNEL_CONTROL, 0, ctl(6'h06, 4'h0), 0);
		apb(0, DSM_OFS_TRANSFER_COUNT, 0, 0, 0);
		$display("test idle done");
	endtask
	task automatic test_repeat();
		apb(1, DSM_OFS_MEMORY_ADDRESS, 32'h0000_0100, 0, 0);
		apb(1, DSM_OFS_IO_ADDRESS_LOW, 32'h0000_ABCD, 0, 0);
		apb(1, DSM_OFS_TRANSFER_COUNT, 32'h0000_0202, 0, 0);
		apb(1, DSM_OFS_CHANNEL_CONTROL, ctl(6'h1D, 4'h6), 0, 0);
		delay <= 4'h6;
		for (int i = 0; i < 4; i++) begin
			xfer(bitof(6), {24'hFFABCD, 24'h100 + 24'(2 * (i % 2)), 2'b10}, ALL, 0, 0);
		end
		apb(1, DSM_OFS_CHANNEL_CONTROL, ctl(6'h1C, 4'h6), 0, 0);
		act_src <= bitof(6);
		@(posedge pclk);
		act_src <= '0;
		repeat (6) @(negedge pclk);
		check("xfer_valid", 0, xfer_valid);
		check("end_irq", 0, end_irq);
		@(posedge pclk);
		apb(0, DSM_OFS_STATUS, 0, 32'h0000_0002, 0);
		apb(1, DSM_OFS_CHANNEL_CONTROL, ctl(6'h1D, 4'h6), 0, 0);
		xfer(0, {24'hFFABCD, 24'h000100, 2'b10}, ALL, 0, 0);
		delay <= 4'h0;
		apb(1, DSM_OFS_MEMORY_ADDRESS, 32'h0000_0200, 0, 0);
		apb(1, DSM_OFS_TRANSFER_COUNT, 32'h0000_0303, 0, 0);
		apb(1, DSM_OFS_CHANNEL_CONTROL, ctl(6'h25, 4'h6), 0, 0);
		for (int i = 0; i < 4; i++) begin
			xfer(bitof(6), {24'h200 - 24'(i % 3), 24'hFFABCD, 2'b00}, ALL, 0, 0);
		end
		apb(1, DSM_OFS_MEMORY_ADDRESS, 32'h0000_0010, 0, 0);
		apb(1, DSM_OFS_TRANSFER_COUNT, 32'h0000_0000, 0, 0);
		apb(1, DSM_OFS_CHANNEL_CONTROL, ctl(6'h05, 4'h6), 0, 0);
		for (int i = 0; i < 257; i++) begin
			xfer(bitof(6), {24'h10 + 24'(i % 256), 24'hFFABCD, 2'b00}, ALL, 0, 0);
		end
		$display("test repeat done");
	endtask
	task automatic test_sources();
		apb(1, DSM_OFS_MEMORY_ADDRESS, 32'h0000_0040, 0, 0);
		apb(1, DSM_OFS_IO_ADDRESS_LOW, 32'h0000_0000, 0, 0);
		apb(1, DSM_OFS_TRANSFER_COUNT, 32'h0000_0000, 0, 0);
		for (int c = 0; c < 10; c++) begin
			apb(1, DSM_OFS_CHANNEL_CONTROL, ctl(6'h07, 4'(c)), 0, 0);
			xfer(bitof(c), {24'h000040, 24'hFF0000, 2'b00}, ALL, 0, 0);
		end
		apb(0, DSM_OFS_TRANSFER_COUNT, 0, 32'h0000_FFF6, 0);
		$display("test sources done");
	endtask
	task automatic test_single();
		a_issues = 0;
		a_single = 0;
		apb(1, DSM_OFS_CHANNEL_PAIR_CONTROL, 32'h0000_0001, 0, 0);
		apb(1, DSM_OFS_MEMORY_ADDRESS, 32'h0000_3000, 0, 0);
		apb(1, DSM_OFS_TRANSFER_COUNT, 32'h0000_0002, 0, 0);
		apb(1, DSM_OFS_CHANNEL_CONTROL, ctl(6'h01, 4'h1), 0, 0);
		for (int i = 0; i < 2; i++) begin
			xfer(bitof(1), {24'h3000 + 24'(i), 24'h0, 2'b01}, {24'hFFFFFF, 24'h0, 2'b11},
				0, 0);
		end
		apb(1, DSM_OFS_TRANSFER_COUNT, 32'h0000_0001, 0, 0);
		apb(1, DSM_OFS_CHANNEL_CONTROL, ctl(6'h09, 4'h1), 0, 0);
		xfer(bitof(1), {24'h0, 24'h003002, 2'b01}, {24'h0, 24'hFFFFFF, 2'b11}, 1, 0);
		check("chan_a_issues", 0, a_issues);
		// Timer source: channel A moves too, but never in single form
		apb(1, DSM_OFS_TRANSFER_COUNT, 32'h0000_0001, 0, 0);
		apb(1, DSM_OFS_CHANNEL_CONTROL, ctl(6'h01, 4'h4), 0, 0);
		xfer(bitof(4), {24'h003003, 24'hFF0000, 2'b01}, ALL, 0, 0);
		check("chan_a_moved", 1, a_issues != 0);
		check("chan_a_single", 0, a_single);
		$display("test single done");
	endtask

	// --------------------------------------------
	// Main sequence
	// --------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, delay} = '0;
		act_src = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		test_regs();
		test_idle();
		test_repeat();
		test_sources();
		test_single();
		stop_test();
	end
endmodule
`default_nettype wire
